// ### hw/ircap_pkg.sv
/*
  ircap_pkg: register map, field layout, reset values and shared types
  for the infrared receive capture and burst-count block.
  assumes a 32-bit apb slave with word-aligned registers.
*/
package ircap_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CARRIER = 8'h04;
    localparam logic [7:0] ADDR_MODTIME = 8'h08;
    localparam logic [7:0] ADDR_COUNT   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_CLEAR   = 8'h14;
    localparam logic [7:0] ADDR_ENABLE  = 8'h18;

    // control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_BIT   = 1;
    localparam int CTRL_CLKSEL_BIT = 2;
    localparam int CTRL_RELOAD_BIT = 3;
    localparam int CTRL_BURST_BIT  = 4;
    localparam int CTRL_EDGE_LSB   = 5;
    localparam int CTRL_DIV_LSB    = 7;
    localparam int CTRL_WIDTH      = 9;

    // status / enable / clear bit positions
    localparam int STAT_IR_INTERRUPT_FLAG_BIT = 0;
    localparam int STAT_OVF_BIT  = 1;
    localparam int STAT_DATA_BIT = 2;
    localparam int EVENT_COUNT   = 2;

    // reset values
    localparam logic [CTRL_WIDTH-1:0]  CTRL_RESET    = 9'h000;
    localparam logic [15:0]            CARRIER_RESET = 16'h0000;
    localparam logic [15:0]            COUNT_RESET   = 16'h0000;
    localparam logic [EVENT_COUNT-1:0] ENABLE_RESET  = 2'h0;

    // carrier periods of silence that mark a space in burst-count mode
    localparam logic [1:0] SPACE_PERIODS = 2'h2;

    // edge selection encodings
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    typedef struct packed {
        logic [1:0] ir_div;
        logic [1:0] edge_select_field;
        logic       burst_count_select;
        logic       rx_reload_ctl;
        logic       count_clock_select;
        logic       tx_rx_mode_bit;
        logic       ir_timer_enable;
    } ircap_ctrl_s;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_ARMED,
        RX_RUN
    } ircap_state_e;

endpackage

// ### hw/ircap_sync.sv
/*
  ircap_sync: two-stage synchroniser for one input level, followed by
  a delay stage for edge detection.
  assumes the input may change at any time relative to pclk.
*/
`timescale 1ns/10ps
module ircap_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta;
    logic stable;
    logic prev;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta   <= RESET_LEVEL;
            stable <= RESET_LEVEL;
            prev   <= RESET_LEVEL;
        end else begin
            meta   <= async_in;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign level = stable;
    assign rise  = stable & ~prev;
    assign fall  = ~stable & prev;

endmodule

// ### hw/ircap_top.sv
/*
  ircap_top: infrared receive capture and carrier burst-count block with
  an apb register slave and one level interrupt.
  assumes ir_receive_pin comes from an off-chip receiver and that the
  apb master follows the usual setup/access sequence on pclk.
*/
`timescale 1ns/10ps
module ircap_top #(
    parameter int COUNT_WIDTH = 16,
    parameter int PRE_WIDTH   = 3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ir_receive_pin,
    output logic             irq
);

    ircap_pkg::ircap_ctrl_s        ctrl;
    ircap_pkg::ircap_state_e       state;
    logic [15:0]                   carrier_period_reg;
    logic [COUNT_WIDTH-1:0]        interval_counter;
    logic [COUNT_WIDTH-1:0]        modulator_time_reg;
    logic                          ir_interrupt_flag;
    logic                          rx_overflow_flag;
    logic                          ir_data_bit;
    logic [ircap_pkg::EVENT_COUNT-1:0] int_enable;
    logic [PRE_WIDTH-1:0]          prescale;
    logic [16:0]                   carrier_count;
    logic [1:0]                    silent_periods;

    logic        rx_level;
    logic        rx_rise;
    logic        rx_fall;
    logic        active;
    logic        qual_edge;
    logic        ir_tick;
    logic        carrier_tick;
    logic        count_tick;
    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;
    logic        clear_ir_interrupt_flag;
    logic        clear_ovf;
    logic        set_ir_interrupt_flag;
    logic        set_ovf;
    logic        capture;
    logic        clear_hit;
    logic        space_hit;
    logic [PRE_WIDTH-1:0] div_mask;
    logic [16:0] carrier_last;
    logic [31:0] next_prdata;

    // pin sync before edges
    // two-flop synchroniser
    ircap_sync #(
        .RESET_LEVEL (1'b1)
    ) u_rx_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ir_receive_pin),
        .level    (rx_level),
        .rise     (rx_rise),
        .fall     (rx_fall)
    );

    assign active = ctrl.ir_timer_enable & ~ctrl.tx_rx_mode_bit;

    always_comb begin
        case (ctrl.edge_select_field)
            ircap_pkg::EDGE_FALL: qual_edge = active & rx_fall;
            ircap_pkg::EDGE_RISE: qual_edge = active & rx_rise;
            default:              qual_edge = active & (rx_rise | rx_fall);
        endcase
    end

    // ir input clock: one tick every 2^div system clocks
    always_comb begin
        div_mask = '0;
        for (int i = 0; i < PRE_WIDTH; i++) begin
            div_mask[i] = (i < int'(ctrl.ir_div));
        end
    end

    assign ir_tick = active & ((prescale & div_mask) == div_mask);

    // the prescaler restarts whenever receive stops, so the first ir tick
    // after enabling is one full ir clock away and never a stray half tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (!active || ir_tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // carrier period is high + low + 2 ir clocks
    assign carrier_last = 17'(carrier_period_reg[15:8]) + 17'(carrier_period_reg[7:0]) + 17'h1;
    assign carrier_tick = ir_tick & (carrier_count >= carrier_last);

    // compare is >= so a carrier value lowered mid-period ends that period
    // at once instead of waiting for the 17-bit count to wrap around
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_count <= '0;
        end else if (!active || carrier_tick) begin
            carrier_count <= '0;
        end else if (ir_tick) begin
            carrier_count <= carrier_count + 17'h1;
        end
    end

    assign count_tick = (state == ircap_pkg::RX_RUN)
                      & (ctrl.count_clock_select ? ir_tick : carrier_tick);

    // armed waits for the first qualified edge; leaving receive mode drops
    // back to idle so a later enable starts a fresh interval from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ircap_pkg::RX_IDLE;
        end else begin
            case (state)
                ircap_pkg::RX_IDLE: begin
                    if (active) begin
                        state <= ircap_pkg::RX_ARMED;
                    end
                end
                ircap_pkg::RX_ARMED: begin
                    if (!active) begin
                        state <= ircap_pkg::RX_IDLE;
                    end else if (qual_edge) begin
                        state <= ircap_pkg::RX_RUN;
                    end
                end
                ircap_pkg::RX_RUN: begin
                    if (!active) begin
                        state <= ircap_pkg::RX_IDLE;
                    end
                end
                default: state <= ircap_pkg::RX_IDLE;
            endcase
        end
    end

    // a capture is an edge after the first one
    assign capture = qual_edge & (state == ircap_pkg::RX_RUN);

    // the counter keeps its value while idle so software can still read the
    // last interval; a narrower COUNT_WIDTH build simply wraps sooner
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_counter <= COUNT_WIDTH'(ircap_pkg::COUNT_RESET);
        end else if (qual_edge && state == ircap_pkg::RX_ARMED) begin
            interval_counter <= '0;
        end else if (capture && ctrl.rx_reload_ctl) begin
            interval_counter <= '0;
        end else if (count_tick) begin
            interval_counter <= interval_counter + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modulator_time_reg <= COUNT_WIDTH'(ircap_pkg::COUNT_RESET);
        end else if (wr_en && paddr == ircap_pkg::ADDR_MODTIME) begin
            modulator_time_reg <= pwdata[COUNT_WIDTH-1:0];
        end else if (qual_edge && ctrl.burst_count_select) begin
            modulator_time_reg <= modulator_time_reg + 1'b1;
        end else if (capture) begin
            modulator_time_reg <= interval_counter;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_data_bit <= 1'b0;
        end else if (qual_edge) begin
            ir_data_bit <= rx_level;
        end
    end

    // space detector counts carrier periods since the last edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            silent_periods <= '0;
        end else if (state != ircap_pkg::RX_RUN || qual_edge) begin
            silent_periods <= '0;
        end else if (carrier_tick && silent_periods != ircap_pkg::SPACE_PERIODS) begin
            silent_periods <= silent_periods + 2'h1;
        end
    end

    // space seen: second carrier tick since the last edge and no edge now;
    // an edge in the same cycle wins so a burst tail is not cut short
    assign space_hit = active
                     & ~qual_edge
                     & carrier_tick
                     & (silent_periods == ircap_pkg::SPACE_PERIODS - 2'h1);

    assign set_ir_interrupt_flag = ctrl.burst_count_select ? space_hit : capture;

    assign set_ovf = count_tick & ~capture & (&interval_counter);

    // write-one-to-clear: zeros leave a flag alone, so software can clear
    // one event without racing the other
    assign clear_hit  = wr_en & (paddr == ircap_pkg::ADDR_CLEAR);
    assign clear_ir_interrupt_flag = clear_hit & pwdata[ircap_pkg::STAT_IR_INTERRUPT_FLAG_BIT];
    assign clear_ovf  = clear_hit & pwdata[ircap_pkg::STAT_OVF_BIT];

    // set beats a simultaneous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_interrupt_flag <= 1'b0;
        end else if (set_ir_interrupt_flag) begin
            ir_interrupt_flag <= 1'b1;
        end else if (clear_ir_interrupt_flag) begin
            ir_interrupt_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_overflow_flag <= 1'b0;
        end else if (set_ovf) begin
            rx_overflow_flag <= 1'b1;
        end else if (clear_ovf) begin
            rx_overflow_flag <= 1'b0;
        end
    end

    // one level line for both events; software reads status to tell them
    // apart, and the line drops as soon as the flag or its enable clears
    // overflow interrupt if enabled
    assign irq = (ir_interrupt_flag & int_enable[ircap_pkg::STAT_IR_INTERRUPT_FLAG_BIT])
               | (rx_overflow_flag & int_enable[ircap_pkg::STAT_OVF_BIT]);

    // apb: zero wait states; read data latched in the setup cycle
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr  = psel & penable & ~addr_ok;

    always_comb begin
        case (paddr)
            ircap_pkg::ADDR_CTRL,
            ircap_pkg::ADDR_CARRIER,
            ircap_pkg::ADDR_MODTIME,
            ircap_pkg::ADDR_COUNT,
            ircap_pkg::ADDR_STATUS,
            ircap_pkg::ADDR_CLEAR,
            ircap_pkg::ADDR_ENABLE: addr_ok = 1'b1;
            default:                addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl               <= ircap_pkg::CTRL_RESET;
            carrier_period_reg <= ircap_pkg::CARRIER_RESET;
            int_enable         <= ircap_pkg::ENABLE_RESET;
        end else if (wr_en) begin
            case (paddr)
                ircap_pkg::ADDR_CTRL:    ctrl <= pwdata[ircap_pkg::CTRL_WIDTH-1:0];
                ircap_pkg::ADDR_CARRIER: carrier_period_reg <= pwdata[15:0];
                ircap_pkg::ADDR_ENABLE:  int_enable <= pwdata[ircap_pkg::EVENT_COUNT-1:0];
                default:                 ;
            endcase
        end
    end

    // clear register reads as zero, it only acts on write
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            ircap_pkg::ADDR_CTRL:    next_prdata[ircap_pkg::CTRL_WIDTH-1:0] = ctrl;
            ircap_pkg::ADDR_CARRIER: next_prdata[15:0] = carrier_period_reg;
            ircap_pkg::ADDR_MODTIME: next_prdata[COUNT_WIDTH-1:0] = modulator_time_reg;
            ircap_pkg::ADDR_COUNT:   next_prdata[COUNT_WIDTH-1:0] = interval_counter;
            ircap_pkg::ADDR_STATUS: begin
                next_prdata[ircap_pkg::STAT_IR_INTERRUPT_FLAG_BIT] = ir_interrupt_flag;
                next_prdata[ircap_pkg::STAT_OVF_BIT]  = rx_overflow_flag;
                next_prdata[ircap_pkg::STAT_DATA_BIT] = ir_data_bit;
            end
            ircap_pkg::ADDR_ENABLE:  next_prdata[ircap_pkg::EVENT_COUNT-1:0] = int_enable;
            default:                 next_prdata = 32'h0000_0000;
        endcase
    end

    // registered so prdata never glitches with the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

endmodule

// ### tb/ircap_top_asserts.sv
/*
  ircap_chk: port-level assertions for ircap_top.
  assumes ctrl and enable change only by apb writes, which it shadows.
*/
`timescale 1ns/10ps
module ircap_chk #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ir_receive_pin,
    input wire logic        irq
);
    localparam int WRAP = 2 ** COUNT_WIDTH;
    ircap_pkg::ircap_ctrl_s c;
    logic [1:0]             en;
    logic [1:0]             edges;
    logic [7:0]             hist;
    logic [COUNT_WIDTH+1:0] quiet;
    logic                   wr;
    logic                   en_wr;
    logic                   ctl_wr;
    logic                   cap;
    logic                   burst;
    assign wr     = psel && penable && pwrite;
    assign en_wr  = wr && paddr == ircap_pkg::ADDR_ENABLE;
    assign ctl_wr = wr && paddr == ircap_pkg::ADDR_CTRL;
    // both edges qualify here, so any pin change is a qualified edge
    assign cap    = c.ir_timer_enable && !c.tx_rx_mode_bit && c.edge_select_field[1];
    assign burst  = cap && c.burst_count_select;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c  <= '0;
            en <= '0;
        end else begin
            if (ctl_wr)
                c <= ircap_pkg::ircap_ctrl_s'(pwdata[8:0]);
            if (en_wr)
                en <= pwdata[1:0];
        end
    end
    // quiet saturates so a long idle never looks like a fresh edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist  <= '1;
            quiet <= '0;
            edges <= '0;
        end else begin
            hist <= {hist[6:0], ir_receive_pin};
            if (hist[0] != ir_receive_pin)
                quiet <= '0;
            else if (~&quiet)
                quiet <= quiet + 1'b1;
            if (ctl_wr)
                edges <= '0;
            else if (hist[0] != ir_receive_pin && edges != 2'h2)
                edges <= edges + 2'h1;
        end
    end
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence rd_status;
        psel && penable && !pwrite && paddr == ircap_pkg::ADDR_STATUS;
    endsequence
    sequence irq_up(logic [1:0] m);
        $rose(irq) && en == m && !$past(en_wr);
    endsequence
    irq_mask_a: assert property (en_wr && pwdata[1:0] == 2'h0 |=> !irq)
        else $error("irq high with enables cleared");
    off_quiet_a: assert property (!c.ir_timer_enable && !irq && !en_wr |=> !irq)
        else $error("irq rose while disabled");
    tx_quiet_a: assert property (c.tx_rx_mode_bit && !irq && !en_wr |=> !irq)
        else $error("irq rose in transmit mode");
    cap_cause_a: assert property (
        (cap && !c.burst_count_select) ##0 irq_up(2'h1) |-> hist != 8'h00 && hist != 8'hff)
        else $error("capture flag without pin edge");
    burst_gap_a: assert property (burst ##0 irq_up(2'h1) |-> quiet >= 8)
        else $error("burst flag too soon after edge");
    burst_space_a: assert property (
        burst && en == 2'h1 && edges != 2'h0 && quiet == 40 |-> irq)
        else $error("space not flagged");
    ovf_early_a: assert property (
        (cap && !burst && c.rx_reload_ctl) ##0 irq_up(2'h2) |-> quiet >= WRAP)
        else $error("overflow before wrap");
    ovf_late_a: assert property (
        cap && !burst && c.rx_reload_ctl && c.count_clock_select && c.ir_div == 2'h0
        && en == 2'h2 && edges != 2'h0 && quiet == WRAP + 8 |-> irq)
        else $error("overflow missing after wrap");
    data_bit_a: assert property (
        (cap && edges == 2'h2 && quiet > 8) ##0 rd_status |-> prdata[2] == hist[0])
        else $error("data bit differs from pin");
endmodule
bind ircap_top ircap_chk #(.COUNT_WIDTH(COUNT_WIDTH)) i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ir_receive_pin, .irq);

// ### tb/ircap_ir_src.sv
/*
  ircap_ir_src: infrared receiver model driving the receive pin.
  assumes callers time levels in pclk cycles from a rising edge.
*/
`timescale 1ns/10ps
module ircap_ir_src (
    input wire logic pclk,
    output logic     ir_receive_pin
);
    // idles high like the pulled-up pin
    initial ir_receive_pin = 1'b1;
    task automatic drive(input logic lvl, input int n);
        ir_receive_pin <= lvl;
        repeat (n) @(posedge pclk);
    endtask
endmodule

// ### tb/ircap_top_tb_top.sv
/*
  ircap_top_tb_top: directed apb tests for ircap_top.
  assumes a 40 MHz pclk and the ir source model on the receive pin.
*/
`timescale 1ns/10ps
module ircap_top_tb_top;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [31:0] mt [3];
    logic [8:0]  cfg [3] = '{9'h04d, 9'h045, 9'h049};
    int          fails = 0;
    int          num_checks = 0;

    always #12.5 pclk = ~pclk;

    // short counter keeps the overflow wait near 260 cycles
    ircap_top #(.COUNT_WIDTH(8), .PRE_WIDTH(3)) i_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ir_receive_pin(pin), .irq);
    ircap_ir_src i_src (.pclk, .ir_receive_pin(pin));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // irq is combinational, so look at it away from the edge
    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        chk("irq", 32'(irq), 32'(exp));
        @(posedge pclk);
    endtask
    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b1, 8'h40, 32'h1);
        chk("unmapped", 32'(err), 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ircap_pkg::ADDR_CLEAR, 32'h3);
            apb(1'b1, ircap_pkg::ADDR_CTRL, 32'(cfg[i]));
            apb(1'b1, ircap_pkg::ADDR_ENABLE, 32'h1);
            i_src.drive(1'b0, 20);
            i_src.drive(1'b1, 40);
            i_src.drive(1'b0, 20);
            apb(1'b0, ircap_pkg::ADDR_MODTIME, 32'h0);
            mt[i] = rd;
            apb(1'b0, ircap_pkg::ADDR_STATUS, 32'h0);
            chk("status", 32'(rd[2:0]), 32'h1); // data low
            chk_irq(1'b1); // capture irq
            apb(1'b0, ircap_pkg::ADDR_COUNT, 32'h0);
            mt[i][31:16] = rd[15:0];
            apb(1'b0, ircap_pkg::ADDR_COUNT, 32'h0);
            if (i == 0)
                chk("count step", 32'(rd[15:0] - mt[i][31:16]), 32'h3); // counting
            apb(1'b1, ircap_pkg::ADDR_CTRL, 32'h0);
            i_src.drive(1'b1, 10);
        end
        chk("reload", 32'(mt[1][15:0] - mt[0][15:0] inside {[19:21]}), 32'h1); // clear
        chk("capture", 32'(mt[0][15:0] inside {[38:42]}), 32'h1); // interval
        chk("carrier", 32'(mt[2][15:0] inside {[19:21]}), 32'h1); // carrier
        apb(1'b1, ircap_pkg::ADDR_CLEAR, 32'h3);
        apb(1'b1, ircap_pkg::ADDR_ENABLE, 32'h2);
        apb(1'b1, ircap_pkg::ADDR_CTRL, 32'h04d);
        i_src.drive(1'b0, 200);
        chk_irq(1'b0); // no early wrap
        repeat (100) @(posedge pclk);
        apb(1'b0, ircap_pkg::ADDR_STATUS, 32'h0);
        chk("overflow", 32'(rd[1]), 32'h1); // wrap flag
        chk_irq(1'b1); // wrap irq
        apb(1'b1, ircap_pkg::ADDR_ENABLE, 32'h0);
        chk_irq(1'b0); // masked
        apb(1'b1, ircap_pkg::ADDR_CTRL, 32'h0);
        i_src.drive(1'b1, 10);
        apb(1'b1, ircap_pkg::ADDR_CLEAR, 32'h3);
        apb(1'b1, ircap_pkg::ADDR_ENABLE, 32'h1);
        apb(1'b1, ircap_pkg::ADDR_CARRIER, 32'h0303);
        apb(1'b1, ircap_pkg::ADDR_MODTIME, 32'h0);
        apb(1'b1, ircap_pkg::ADDR_CTRL, 32'h059);
        for (int i = 0; i < 3; i++) begin
            i_src.drive(1'b0, 1);
            i_src.drive(1'b1, 1);
        end
        repeat (5) @(posedge pclk);
        chk_irq(1'b0); // no capture flag
        repeat (40) @(posedge pclk);
        apb(1'b0, ircap_pkg::ADDR_MODTIME, 32'h0);
        chk("bursts", rd, 32'h6); // edge count
        chk_irq(1'b1); // space flag
        apb(1'b1, ircap_pkg::ADDR_ENABLE, 32'h3);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ircap_pkg::ADDR_CLEAR, 32'h3);
            apb(1'b1, ircap_pkg::ADDR_CTRL, i == 0 ? 32'h047 : 32'h044);
            i_src.drive(1'b0, 30);
            i_src.drive(1'b1, 300);
            apb(1'b0, ircap_pkg::ADDR_STATUS, 32'h0);
            chk("stopped", 32'(rd[1:0]), 32'h0); // stopped
            chk_irq(1'b0); // receive only
        end
        end_of_test();
    end
endmodule
